// ===== dv/fbh_flash_model.sv
// Behavioural byte-wide flash device seen from the host controller's pins.
// Assumes pins driven by fbh_host; timing is in ns, not tied to mclk.
`timescale 1ns/1ps
module fbh_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h3c, // Arbitrary identification value
  parameter int BUSY_NS = 300,
  parameter int RST_NS = 200
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic unprotect_high_voltage,
  input wire logic [fbh_pkg::ADDR_W-1:0] addr_in,
  input wire logic [fbh_pkg::DATA_W-1:0] data_io_out,
  input wire logic data_io_oe,
  output logic [fbh_pkg::DATA_W-1:0] data_io_in,
  output logic ready_busy_n
);
  // ********************************************************************
  // Array, mode and status
  // ********************************************************************
  logic [7:0] mem [int];
  logic idMode = 1'b0;
  logic armed = 1'b0;
  logic wsel = 1'b0;
  logic [21:0] wa, progAddr;
  logic [7:0] wd, progData = 8'h00, rdata, lastVal = 8'h00;
  logic drive;
  event progGo;
  initial ready_busy_n = 1'b1;
  // Only enabled reads drive; latches never show up as addresses
  assign drive = (ce_n === 1'b0) && (oe_n === 1'b0) && (we_n === 1'b1) && (reset_n === 1'b1);
  always @* begin
    if (!ready_busy_n) rdata = {~progData[7], 7'h40};
    else if (idMode) rdata = ID_CODE;
    else rdata = mem.exists(addr_in) ? mem[addr_in] : addr_in[7:0] ^ 8'h5a;
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  always @* if (drive) lastVal = rdata;
  assign data_io_in = drive ? rdata : ~lastVal;
  // Capture while the write strobe is low, act on its rising edge
  // Chip enable may rise with the strobe, so selection is judged while the strobe is low
  always @(addr_in, data_io_out, we_n, ce_n, oe_n) if (we_n === 1'b0) begin
    wa = addr_in;
    wd = data_io_out;
    wsel = (ce_n === 1'b0) && (oe_n === 1'b1);
  end
  always @(posedge we_n) if (reset_n === 1'b1 && wsel && ready_busy_n) begin
    if (armed) begin
      armed = 1'b0;
      progAddr = wa;
      progData = wd;
      ->progGo;
    end else begin
      idMode = (wd == 8'h90);
      armed = (wd == 8'ha0);
    end
  end
  // Embedded program runs on even when deselected
  always @(progGo) begin : progRun
    ready_busy_n = 1'b0;
    #BUSY_NS;
    mem[progAddr] = progData;
    ready_busy_n = 1'b1;
  end
  // Reset aborts the operation and returns to array read
  always @(negedge reset_n) begin
    disable progRun;
    idMode = 1'b0;
    armed = 1'b0;
    if (!ready_busy_n) #RST_NS ready_busy_n = 1'b1;
  end
endmodule // fbh_flash_model

// ===== dv/testbench.sv
// Self-checking bench for fbh_host against the behavioural flash model.
// Assumes 100 MHz mclk; stimulus changes at the falling edge.
`timescale 1ns/1ps
module testbench;
  // ********************************************************************
  // Signals, DUT and device model
  // ********************************************************************
  logic mclk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqReady, rspValid, flashReady, interruptedOp;
  logic ce_n, oe_n, we_n, reset_n, unprotect_high_voltage, data_io_oe, ready_busy_n;
  fbh_pkg::fbh_op_t reqOp = fbh_pkg::FBH_OP_READ;
  logic [21:0] reqAddr = 22'h00_0000, addr_in;
  logic [7:0] reqData = 8'h00, rspData, data_io_out, data_io_in;
  int n_fail = 0, checks = 0, n;
  realtime tCe, tRst;
  fbh_host DUT (.mclk(mclk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
    .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .flashReady(flashReady),
    .interruptedOp(interruptedOp), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
    .unprotect_high_voltage(unprotect_high_voltage), .addr_in(addr_in), .data_io_out(data_io_out),
    .data_io_oe(data_io_oe), .data_io_in(data_io_in), .ready_busy_n(ready_busy_n));
  fbh_flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
    .unprotect_high_voltage(unprotect_high_voltage), .addr_in(addr_in), .data_io_out(data_io_out),
    .data_io_oe(data_io_oe), .data_io_in(data_io_in), .ready_busy_n(ready_busy_n));
  initial forever #5 mclk = ~mclk;
  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic test_done();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic waitSig(ref logic s, input logic v, input int lim, input string nm);
    for (int i = 0; i < lim && s !== v; i++) @(negedge mclk);
    if (s !== v) begin
      chk({"timeout ", nm}, s, v);
      test_done();
    end
  endtask
  task automatic req(input fbh_pkg::fbh_op_t op, input logic [21:0] a, input logic [7:0] d);
    waitSig(reqReady, 1'b1, 200, "reqReady");
    reqOp = op;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    @(negedge mclk);
    reqValid = 1'b0;
  endtask
  task automatic rd(input logic [21:0] a, input logic [7:0] exp);
    req(fbh_pkg::FBH_OP_READ, a, 8'h00);
    waitSig(ce_n, 1'b0, 10, "ce_n");
    tCe = $realtime;
    chk("read pins", {oe_n, we_n, reset_n, data_io_oe, addr_in}, {4'b0110, a});
    waitSig(rspValid, 1'b1, 20, "rspValid");
    chk("rspData", rspData, exp);
  endtask
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    req(fbh_pkg::FBH_OP_WRITE, a, d);
    waitSig(we_n, 1'b0, 10, "we_n");
    chk("write ctl", {ce_n, oe_n, data_io_oe}, 3'b011);
    chk("write bus", {data_io_out, addr_in}, {d, a});
  endtask
  // ********************************************************************
  // Ordinary cases: op, address, write data or expected read byte
  // ********************************************************************
  typedef struct {fbh_pkg::fbh_op_t op; logic [21:0] a; logic [7:0] d;} row_t;
  row_t rows [9] = '{
    '{fbh_pkg::FBH_OP_READ, 22'h00_0010, 8'h4a}, '{fbh_pkg::FBH_OP_READ, 22'h3f_ffff, 8'ha5},
    '{fbh_pkg::FBH_OP_WRITE, 22'h00_0555, 8'h90}, '{fbh_pkg::FBH_OP_READ, 22'h00_0001, 8'h3c},
    '{fbh_pkg::FBH_OP_WRITE, 22'h00_0000, 8'h30}, '{fbh_pkg::FBH_OP_READ, 22'h00_0001, 8'h5b},
    '{fbh_pkg::FBH_OP_WRITE, 22'h00_0aaa, 8'ha0}, '{fbh_pkg::FBH_OP_WRITE, 22'h00_1234, 8'h77},
    '{fbh_pkg::FBH_OP_READ, 22'h00_1234, 8'hc0}};
  initial begin
    repeat (5) @(negedge mclk);
    chk("pins in reset", {ce_n, oe_n, we_n, reset_n, data_io_oe}, 5'b11100);
    nrst = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].op == fbh_pkg::FBH_OP_READ) rd(rows[i].a, rows[i].d);
      else wr(rows[i].a, rows[i].d);
    end
    // Program completes, then the new byte reads back
    waitSig(flashReady, 1'b1, 100, "flashReady");
    chk("ready pin", ready_busy_n, 1'b1);
    rd(22'h00_1234, 8'h77);
    // Reset in mid-program: pulse width, abort, recovery, restart
    wr(22'h00_0aaa, 8'ha0);
    wr(22'h00_2000, 8'h33);
    req(fbh_pkg::FBH_OP_RESET, 22'h00_0000, 8'h00);
    waitSig(reset_n, 1'b0, 10, "reset_n low");
    chk("busy in reset", {ready_busy_n, flashReady}, 2'b00);
    for (n = 0; n < 200 && reset_n === 1'b0; n++) @(negedge mclk);
    tRst = $realtime;
    chk("reset width ok", n >= fbh_pkg::RESET_PULSE_CYC, 1'b1);
    chk("interruptedOp", interruptedOp, 1'b1);
    rd(22'h00_2000, 8'h5a);
    chk("recovery ok", (tCe - tRst) >= fbh_pkg::RESET_RECOVER_CYC * 10.0, 1'b1);
    wr(22'h00_0aaa, 8'ha0);
    chk("interruptedOp clear", interruptedOp, 1'b0);
    wr(22'h00_2000, 8'h33);
    waitSig(flashReady, 1'b1, 100, "flashReady");
    rd(22'h00_2000, 8'h33);
    // Elevated-voltage write carries address and data
    req(fbh_pkg::FBH_OP_UNPROT, 22'h2a_5a5a, 8'h6c);
    waitSig(unprotect_high_voltage, 1'b1, 10, "unprotect");
    chk("unprotect pins", {data_io_oe, data_io_out, addr_in}, {1'b1, 8'h6c, 22'h2a_5a5a});
    test_done();
  end
endmodule // testbench

// ===== rtl/fbh_host.sv
// Host controller that runs read, write, reset and unprotect cycles on a byte-wide flash bus.
// Assumes the flash data and ready/busy pins are asynchronous and are synchronised here.
// Functional notes
// - Read with chip and output enable low, write enable high, reset high.
// - Write with write and chip enable low, output enable high.
// - Host flags an interrupted program or erase after reset; the user reissues it.
// - Host waits reset-recovery time after reset high before reading.
// - Elevated reset voltage accepts addresses and data, enables don't care.
`timescale 1ns/1ps
module fbh_host (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire fbh_pkg::fbh_op_t reqOp,
  input wire logic [fbh_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [fbh_pkg::DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [fbh_pkg::DATA_W-1:0] rspData,
  output logic flashReady,
  output logic interruptedOp,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic reset_n,
  output logic unprotect_high_voltage,
  output logic [fbh_pkg::ADDR_W-1:0] addr_in,
  output logic [fbh_pkg::DATA_W-1:0] data_io_out,
  output logic data_io_oe,
  input wire logic [fbh_pkg::DATA_W-1:0] data_io_in,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {FBH_IDLE, FBH_RD, FBH_WR, FBH_RST, FBH_RECOV, FBH_UNP, FBH_GAP} fbh_state_t;
  fbh_state_t state_reg;
  logic [fbh_pkg::CNT_W-1:0] cnt_reg;
  logic [fbh_pkg::DATA_W-1:0] dataMeta_reg;
  logic [fbh_pkg::DATA_W-1:0] dataSync_reg;
  logic rbMeta_reg;
  logic rbSync_reg;
  logic busySeen_reg;
  logic [fbh_pkg::ADDR_W-1:0] addr_reg;
  logic [fbh_pkg::DATA_W-1:0] wdata_reg;
  fbh_pins_if pins();
  // Pin register plus two synchroniser flops between a write's end and a visible busy level
  localparam logic [1:0] SETTLE_CYC = 2'h3;
  logic [1:0] settle_reg;
  logic [fbh_pkg::CNT_W-1:0] rstLow_reg;

  // Count load helper: converts an int cycle figure to the counter width
  function automatic logic [fbh_pkg::CNT_W-1:0] cyc(input int n);
    cyc = fbh_pkg::CNT_W'(n - 1);
  endfunction

  // ********************************************************************
  // Input synchronisers: pins are outside mclk's domain
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dataMeta_reg <= '0;
      dataSync_reg <= '0;
      rbMeta_reg <= 1'b1; // Idle level of the ready pin, so no false busy after reset
      rbSync_reg <= 1'b1;
    end else begin
      dataMeta_reg <= data_io_in;
      dataSync_reg <= dataMeta_reg;
      rbMeta_reg <= ready_busy_n;
      rbSync_reg <= rbMeta_reg;
    end
  end

  // Busy lags a write by the pin register and the synchroniser; hide ready until it can show
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      settle_reg <= 2'h0;
    end else if (state_reg == FBH_WR || state_reg == FBH_UNP) begin
      settle_reg <= SETTLE_CYC;
    end else if (settle_reg != 2'h0) begin
      settle_reg <= settle_reg - 1'b1;
    end
  end

  // Ready only when the flash reports no embedded work or reset
  assign flashReady = rbSync_reg && (state_reg == FBH_IDLE) && (settle_reg == 2'h0);
  // Handshake: take requests only when idle; writes do not wait for ready
  assign reqReady = (state_reg == FBH_IDLE);

  // ********************************************************************
  // Cycle sequencer
  // ********************************************************************
  // One request at a time; cnt_reg times each phase from the package figures
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg <= FBH_RST;
      cnt_reg <= cyc(fbh_pkg::RESET_PULSE_CYC);
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      case (state_reg)
        FBH_IDLE: begin
          if (reqValid) begin
            addr_reg <= reqAddr;
            wdata_reg <= reqData;
            case (reqOp)
              fbh_pkg::FBH_OP_READ: begin
                state_reg <= FBH_RD;
                cnt_reg <= cyc(fbh_pkg::ACCESS_CYC + 3); // Extra three cover the pin register and synchroniser
              end
              fbh_pkg::FBH_OP_WRITE: begin
                state_reg <= FBH_WR;
                cnt_reg <= cyc(fbh_pkg::WRITE_PULSE_CYC);
              end
              fbh_pkg::FBH_OP_RESET: begin
                state_reg <= FBH_RST;
                cnt_reg <= cyc(fbh_pkg::RESET_PULSE_CYC);
              end
              default: begin
                state_reg <= FBH_UNP;
                cnt_reg <= cyc(fbh_pkg::WRITE_PULSE_CYC);
              end
            endcase
          end
        end
        FBH_RST: begin
          // Reset held at least the minimum pulse width
          if (cnt_reg == '0) begin
            state_reg <= FBH_RECOV;
            cnt_reg <= cyc(fbh_pkg::RESET_RECOVER_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        FBH_RD, FBH_WR, FBH_UNP, FBH_RECOV: begin
          // Recovery waits before any read is allowed
          if (cnt_reg == '0) begin
            state_reg <= (state_reg == FBH_RECOV) ? FBH_IDLE : FBH_GAP;
            cnt_reg <= cyc(fbh_pkg::SETUP_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          if (cnt_reg == '0) begin
            state_reg <= FBH_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // ********************************************************************
  // Pin levels per state
  // ********************************************************************
  // Combinational levels; fbh_pin_reg registers them onto the pins
  always_comb begin
    pins.ceN = 1'b1;
    pins.oeN = 1'b1;
    pins.weN = 1'b1;
    pins.resetN = 1'b1;
    pins.unprotHigh = 1'b0;
    pins.addr = addr_reg;
    pins.wdata = wdata_reg;
    pins.dataOe = 1'b0;
    case (state_reg)
      FBH_RD: begin
        pins.ceN = 1'b0;
        pins.oeN = 1'b0;
      end
      FBH_WR: begin
        pins.ceN = 1'b0;
        pins.weN = 1'b0;
        pins.dataOe = 1'b1;
      end
      FBH_RST: pins.resetN = 1'b0;
      FBH_UNP: begin
        pins.unprotHigh = 1'b1;
        pins.dataOe = 1'b1;
      end
      default: ;
    endcase
  end

  fbh_pin_reg u_pins (
    .mclk(mclk),
    .nrst(nrst),
    .pins(pins),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .reset_n(reset_n),
    .unprotect_high_voltage(unprotect_high_voltage),
    .addr_in(addr_in),
    .data_io_out(data_io_out),
    .data_io_oe(data_io_oe)
  );

  // ********************************************************************
  // Read answer and interrupted-operation flag
  // ********************************************************************
  // Sample at the end of the read window; status or codes arrive the same way
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      rspValid <= (state_reg == FBH_RD) && (cnt_reg == '0);
      if ((state_reg == FBH_RD) && (cnt_reg == '0)) begin
        rspData <= dataSync_reg;
      end
    end
  end

  // A reset pulse that finds the flash busy flags that the user must reissue the operation
  // Judged during the pulse: busy lasts into its first part, while at the request it may not have arrived yet
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busySeen_reg <= 1'b0;
      interruptedOp <= 1'b0;
    end else begin
      busySeen_reg <= !rbSync_reg;
      if (state_reg == FBH_RST && busySeen_reg) begin
        interruptedOp <= 1'b1;
      end else if (state_reg == FBH_IDLE && reqValid && reqOp == fbh_pkg::FBH_OP_WRITE) begin
        interruptedOp <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence rdStart_s;
    state_reg == FBH_IDLE && reqValid && reqOp == fbh_pkg::FBH_OP_READ;
  endsequence
  read_pins_a: assert property (@(posedge mclk) disable iff (!nrst)
    rdStart_s |-> ##2 (!ce_n && !oe_n && we_n && reset_n)) else $error("read pin levels wrong");
  write_pins_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == FBH_WR |=> (!ce_n && !we_n && oe_n)) else $error("write pin levels wrong");
  // Counts low cycles of the reset pin, since the minimum pulse is too long for a repetition
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rstLow_reg <= '0;
    end else if (reset_n) begin
      rstLow_reg <= '0;
    end else if (rstLow_reg != '1) begin
      rstLow_reg <= rstLow_reg + 1'b1;
    end
  end
  reset_width_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(reset_n) |-> int'(rstLow_reg) >= fbh_pkg::RESET_PULSE_CYC) else $error("reset pulse too short");
  recover_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(reset_n) |-> oe_n [*5]) else $error("read too soon after reset");
  read_answer_a: assert property (@(posedge mclk) disable iff (!nrst)
    rdStart_s |-> ##11 rspValid) else $error("read answer late");
  unprot_level_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == FBH_UNP |=> unprotect_high_voltage && data_io_oe) else $error("unprotect not driven");
  no_fight_a: assert property (@(posedge mclk) disable iff (!nrst)
    data_io_oe |-> oe_n) else $error("bus contention");
  ready_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    flashReady |-> (reset_n && ce_n && we_n)) else $error("ready while bus active");
endmodule // fbh_host

// ===== rtl/fbh_pin_reg.sv
// Output register stage that drives the flash pins from the sequencer.
// Assumes the sequencer bundle is on mclk; every pin leaves a flip-flop.
`timescale 1ns/1ps
module fbh_pin_reg (
  input wire logic mclk,
  input wire logic nrst,
  fbh_pins_if.drv pins,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic reset_n,
  output logic unprotect_high_voltage,
  output logic [fbh_pkg::ADDR_W-1:0] addr_in,
  output logic [fbh_pkg::DATA_W-1:0] data_io_out,
  output logic data_io_oe
);
  // ********************************************************************
  // Pin registers: reset state deselects the flash and holds it in reset
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      reset_n <= 1'b0;
      unprotect_high_voltage <= 1'b0;
      addr_in <= '0;
      data_io_out <= '0;
      data_io_oe <= 1'b0;
    end else begin
      ce_n <= pins.ceN;
      oe_n <= pins.oeN;
      we_n <= pins.weN;
      reset_n <= pins.resetN;
      unprotect_high_voltage <= pins.unprotHigh;
      addr_in <= pins.addr;
      data_io_out <= pins.wdata;
      data_io_oe <= pins.dataOe;
    end
  end
endmodule // fbh_pin_reg

// ===== rtl/fbh_pins_if.sv
// Pin bundle between the bus sequencer and the pin driver.
// Assumes a single mclk domain; outputs are registered by the driver.
`timescale 1ns/1ps
interface fbh_pins_if;
  logic ceN;
  logic oeN;
  logic weN;
  logic resetN;
  logic unprotHigh;
  logic [fbh_pkg::ADDR_W-1:0] addr;
  logic [fbh_pkg::DATA_W-1:0] wdata;
  logic dataOe;
  modport seq (output ceN, oeN, weN, resetN, unprotHigh, addr, wdata, dataOe);
  modport drv (input ceN, oeN, weN, resetN, unprotHigh, addr, wdata, dataOe);
endinterface

// ===== rtl/fbh_pkg.sv
// Shared constants and types for the flash bus host controller.
// Assumes a 100 MHz mclk; timing counts derive from nanosecond figures.
package fbh_pkg;
  // ********************************************************************
  // Clock and bus geometry
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  // ********************************************************************
  // Bus cycle timing (nanoseconds, then cycles rounded up)
  // ********************************************************************
  localparam int ACCESS_NS = 70;               // Address and enable to valid data
  localparam int WRITE_PULSE_NS = 40;          // Write enable low time
  localparam int SETUP_NS = 10;                // Recovery between cycles
  localparam int RESET_PULSE_MIN_NS = 500;     // reset_pulse_min
  localparam int RESET_HIGH_TO_READ_NS = 50;   // reset_high_to_read
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVER_CYC = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ********************************************************************
  // Request kinds from the user side
  // ********************************************************************
  typedef enum logic [1:0] {FBH_OP_READ, FBH_OP_WRITE, FBH_OP_RESET, FBH_OP_UNPROT} fbh_op_t;
endpackage
